/* File: logic/qpr_pkg.sv */
package qpr_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 9;
    localparam int NET_COUNT = 4;
    localparam int TCON_COUNT = 2;

    // register offsets
    localparam logic [3:0] ADDR_WIPER_POS_0 = 4'h0;
    localparam logic [3:0] ADDR_WIPER_POS_1 = 4'h1;
    localparam logic [3:0] ADDR_TERM_CTRL_LOW = 4'h4;
    localparam logic [3:0] ADDR_WIPER_POS_2 = 4'h6;
    localparam logic [3:0] ADDR_WIPER_POS_3 = 4'h7;
    localparam logic [3:0] ADDR_TERM_CTRL_HIGH = 4'ha;

    // reset values and wiper end codes
    localparam logic [8:0] WIPER_RESET_8BIT = 9'h080;
    localparam logic [8:0] WIPER_RESET_7BIT = 9'h040;
    localparam logic [8:0] WIPER_FULL_8BIT = 9'h100;
    localparam logic [8:0] WIPER_FULL_7BIT = 9'h080;
    localparam logic [8:0] WIPER_ZERO = 9'h000;
    localparam logic [8:0] TCON_RESET = 9'h1ff;

    // terminal control field positions
    localparam int TCON_TOP_BIT = 8;
    localparam int NIB_END_B = 0;
    localparam int NIB_WIPER = 1;
    localparam int NIB_END_A = 2;
    localparam int NIB_SHUTDOWN = 3;
    localparam int NIB_WIDTH = 4;

    typedef enum logic [1:0] {
        QPR_OP_WRITE = 2'b00,
        QPR_OP_INCR  = 2'b01,
        QPR_OP_DECR  = 2'b10,
        QPR_OP_READ  = 2'b11
    } qpr_op_type;

    typedef enum logic [2:0] {
        QPR_ST_OK       = 3'b001,
        QPR_ST_ERR      = 3'b010,
        QPR_ST_ERR_DESEL = 3'b100
    } qpr_err_state_type;

    // {hit, index} of a wiper address
    function automatic logic [2:0] qpr_wiper_slot(input logic [3:0] addr);
        logic [2:0] slot;
        slot = 3'b000;
        case (addr)
            ADDR_WIPER_POS_0: slot = 3'b100;
            ADDR_WIPER_POS_1: slot = 3'b101;
            ADDR_WIPER_POS_2: slot = 3'b110;
            ADDR_WIPER_POS_3: slot = 3'b111;
            default:          slot = 3'b000;
        endcase
        return slot;
    endfunction

endpackage

/* File: logic/qpr_cmd_if.sv */
`timescale 1ns/1ns
interface qpr_cmd_if;
    import qpr_pkg::*;

    logic [3:0] addr;
    qpr_op_type op;
    logic       legal;
    logic       wiper_hit;
    logic [1:0] wiper_idx;
    logic       tcon_hit;
    logic       tcon_idx;

    modport decode (
        input  addr,
        input  op,
        output legal,
        output wiper_hit,
        output wiper_idx,
        output tcon_hit,
        output tcon_idx
    );

    modport core (
        output addr,
        output op,
        input  legal,
        input  wiper_hit,
        input  wiper_idx,
        input  tcon_hit,
        input  tcon_idx
    );
endinterface

/* File: logic/qpr_access_check.sv */
`timescale 1ns/1ns
module qpr_access_check
    import qpr_pkg::*;
(
    qpr_cmd_if.decode bus
);

    logic [2:0] slot;
    logic       tcon_any;

    assign slot = qpr_wiper_slot(bus.addr);
    assign bus.wiper_hit = slot[2];
    assign bus.wiper_idx = slot[1:0];

    assign tcon_any = (bus.addr == ADDR_TERM_CTRL_LOW) ||
                      (bus.addr == ADDR_TERM_CTRL_HIGH);
    assign bus.tcon_hit = tcon_any;
    assign bus.tcon_idx = (bus.addr == ADDR_TERM_CTRL_HIGH);

    // wipers take all four ops, tcon only read/write, rest nothing
    always_comb begin
        bus.legal = 1'b0;
        if (slot[2]) begin
            bus.legal = 1'b1;
        end else if (tcon_any) begin
            bus.legal = (bus.op == QPR_OP_READ) ||
                        (bus.op == QPR_OP_WRITE);
        end else begin
            bus.legal = 1'b0;
        end
    end

endmodule // qpr_access_check

/* File: logic/qpr_regmap.sv */
`timescale 1ns/1ns
module qpr_regmap
    import qpr_pkg::*;
#(
    parameter int WIPER_BITS = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             cs_n,
    input  wire logic             reset_pin_n,
    input  wire logic             cmd_valid,
    input  wire qpr_op_type       cmd_op,
    input  wire logic [3:0]       cmd_addr,
    input  wire logic [8:0]       cmd_wdata,
    input  wire logic             cmd_complete,
    output logic                  cmd_accept,
    output logic                  cmd_error,
    output logic                  rd_valid,
    output logic [8:0]            rd_data,
    output logic [3:0][8:0]       wiper_code,
    output logic [3:0]            net_shutdown,
    output logic [3:0]            end_a_connect,
    output logic [3:0]            wiper_connect,
    output logic [3:0]            end_b_connect
);

    localparam logic [8:0] WIPER_MID =
        (WIPER_BITS == 7) ? WIPER_RESET_7BIT : WIPER_RESET_8BIT;
    localparam logic [8:0] WIPER_FULL =
        (WIPER_BITS == 7) ? WIPER_FULL_7BIT : WIPER_FULL_8BIT;

    logic [2:0]        cs_sync_reg;
    logic [2:0]        pin_sync_reg;
    logic              cs_n_reg;
    logic              pin_n_reg;
    logic              sel_active;
    logic              hold_reset;
    logic              take;
    logic              exec;
    logic              bad;
    qpr_err_state_type state_reg;
    qpr_err_state_type state_next;
    logic [8:0]        wiper_reg [NET_COUNT];
    logic [8:0]        tcon_reg [TCON_COUNT];
    logic [8:0]        tcon_live_reg [TCON_COUNT];
    logic              rd_valid_reg;
    logic [8:0]        rd_data_reg;

    qpr_cmd_if cmd_bus ();

    assign cmd_bus.addr = cmd_addr;
    assign cmd_bus.op = cmd_op;

    qpr_access_check u_check (
        .bus (cmd_bus)
    );

    // pin inputs: three stages, a change counts once stages 2 and 3 agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_sync_reg <= 3'b111;
            pin_sync_reg <= 3'b111;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
            pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_n};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_n_reg <= 1'b1;
            pin_n_reg <= 1'b1;
        end else begin
            if (cs_sync_reg[1] == cs_sync_reg[2]) begin
                cs_n_reg <= cs_sync_reg[2];
            end
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pin_n_reg <= pin_sync_reg[2];
            end
        end
    end

    assign sel_active = !cs_n_reg;
    assign hold_reset = !pin_n_reg;

    // commands are dropped while the reset pin is held or in QPR_ST_ERR
    assign take = cmd_valid && sel_active && !hold_reset &&
                  (state_reg != QPR_ST_ERR);
    assign exec = take && cmd_bus.legal;
    assign bad = take && !cmd_bus.legal;

    // error tracking: set on a rejected command, cleared by cs cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            QPR_ST_OK: begin
                if (bad) begin
                    state_next = QPR_ST_ERR;
                end
            end
            QPR_ST_ERR: begin
                if (cs_n_reg) begin
                    state_next = QPR_ST_ERR_DESEL;
                end
            end
            QPR_ST_ERR_DESEL: begin
                if (sel_active) begin
                    // a new reject in the clearing cycle wins
                    state_next = bad ? QPR_ST_ERR : QPR_ST_OK;
                end
            end
            default: begin
                state_next = QPR_ST_OK;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= QPR_ST_OK;
        end else if (hold_reset) begin
            state_reg <= QPR_ST_OK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cmd_error = (state_reg != QPR_ST_OK);
    assign cmd_accept = exec;

    // wiper registers, saturating at zero (end B) and full scale (end A)
    for (genvar i = 0; i < NET_COUNT; i++) begin : g_wiper
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                wiper_reg[i] <= WIPER_MID;
            end else if (hold_reset) begin
                wiper_reg[i] <= WIPER_MID;
            end else if (exec && cmd_bus.wiper_hit &&
                         (cmd_bus.wiper_idx == 2'(i))) begin
                case (cmd_op)
                    QPR_OP_WRITE: begin
                        wiper_reg[i] <= (cmd_wdata > WIPER_FULL) ?
                                        WIPER_FULL : cmd_wdata;
                    end
                    QPR_OP_INCR: begin
                        if (wiper_reg[i] < WIPER_FULL) begin
                            wiper_reg[i] <= wiper_reg[i] + 9'h001;
                        end
                    end
                    QPR_OP_DECR: begin
                        if (wiper_reg[i] > WIPER_ZERO) begin
                            wiper_reg[i] <= wiper_reg[i] - 9'h001;
                        end
                    end
                    default: begin
                        wiper_reg[i] <= wiper_reg[i];
                    end
                endcase
            end
        end
        assign wiper_code[i] = wiper_reg[i];
    end

    // terminal control: stored value, then live copy applied on completion
    for (genvar t = 0; t < TCON_COUNT; t++) begin : g_tcon
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                tcon_reg[t] <= TCON_RESET;
            end else if (hold_reset) begin
                tcon_reg[t] <= TCON_RESET;
            end else if (exec && cmd_bus.tcon_hit &&
                         (cmd_bus.tcon_idx == 1'(t)) &&
                         (cmd_op == QPR_OP_WRITE)) begin
                tcon_reg[t] <= {1'b1, cmd_wdata[7:0]};
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                tcon_live_reg[t] <= TCON_RESET;
            end else if (hold_reset) begin
                tcon_live_reg[t] <= TCON_RESET;
            end else if (cmd_complete) begin
                tcon_live_reg[t] <= tcon_reg[t];
            end
        end
    end

    // per-network terminal switches; networks 1 and 3 use the upper nibble
    for (genvar n = 0; n < NET_COUNT; n++) begin : g_net
        localparam int REG_SEL = n / 2;
        localparam int BASE = (n % 2) * NIB_WIDTH;
        assign net_shutdown[n] =
            !tcon_live_reg[REG_SEL][BASE + NIB_SHUTDOWN];
        assign end_a_connect[n] =
            tcon_live_reg[REG_SEL][BASE + NIB_END_A];
        assign wiper_connect[n] =
            tcon_live_reg[REG_SEL][BASE + NIB_WIPER];
        assign end_b_connect[n] =
            tcon_live_reg[REG_SEL][BASE + NIB_END_B];
    end

    // read path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= exec && (cmd_op == QPR_OP_READ);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 9'h000;
        end else if (exec && (cmd_op == QPR_OP_READ)) begin
            if (cmd_bus.wiper_hit) begin
                rd_data_reg <= wiper_reg[cmd_bus.wiper_idx];
            end else begin
                rd_data_reg <= tcon_reg[cmd_bus.tcon_idx];
            end
        end
    end

    assign rd_valid = rd_valid_reg;
    assign rd_data = rd_data_reg;

    // checks
    chk_pin_defaults: assert property (
        @(posedge clk) disable iff (rst)
        hold_reset |=> (wiper_reg[0] == WIPER_MID) &&
                       (wiper_reg[3] == WIPER_MID) &&
                       (tcon_reg[0] == TCON_RESET) &&
                       (tcon_reg[1] == TCON_RESET))
        else $error("reset pin did not restore defaults");

    chk_pin_blocks_cmd: assert property (
        @(posedge clk) disable iff (rst)
        hold_reset |-> !cmd_accept && !rd_valid_reg ##1 !rd_valid_reg)
        else $error("command taken while reset pin held");

    chk_wiper_incr: assert property (
        @(posedge clk) disable iff (rst)
        exec && (cmd_addr == ADDR_WIPER_POS_2) &&
        (cmd_op == QPR_OP_INCR) && (wiper_reg[2] < WIPER_FULL)
        |=> wiper_reg[2] == $past(wiper_reg[2]) + 9'h001)
        else $error("wiper increment wrong");

    chk_wiper_floor: assert property (
        @(posedge clk) disable iff (rst)
        exec && (cmd_addr == ADDR_WIPER_POS_3) &&
        (cmd_op == QPR_OP_DECR) && (wiper_reg[3] == WIPER_ZERO)
        |=> wiper_reg[3] == WIPER_ZERO)
        else $error("wiper decremented below zero");

    chk_tcon_no_step: assert property (
        @(posedge clk) disable iff (rst)
        take && cmd_bus.tcon_hit &&
        ((cmd_op == QPR_OP_INCR) || (cmd_op == QPR_OP_DECR))
        |=> cmd_error && $stable(tcon_reg[0]) && $stable(tcon_reg[1]))
        else $error("step command on terminal control not rejected");

    chk_reserved_err: assert property (
        @(posedge clk) disable iff (rst)
        take && !cmd_bus.wiper_hit &&
        (cmd_addr != ADDR_TERM_CTRL_LOW) &&
        (cmd_addr != ADDR_TERM_CTRL_HIGH)
        |-> !cmd_accept ##1 cmd_error && !rd_valid_reg)
        else $error("reserved address not rejected");

    chk_error_clear: assert property (
        @(posedge clk) disable iff (rst)
        $fell(cmd_error) && !$past(hold_reset)
        |-> ($past(state_reg) == QPR_ST_ERR_DESEL) && $past(sel_active))
        else $error("error cleared without cs cycle");

    chk_error_holds: assert property (
        @(posedge clk) disable iff (rst)
        (state_reg == QPR_ST_ERR) && sel_active && !hold_reset
        |=> cmd_error)
        else $error("error dropped while still selected");

    chk_tcon_apply: assert property (
        @(posedge clk) disable iff (rst)
        !cmd_complete && !hold_reset |=> $stable(tcon_live_reg[0]) &&
                                         $stable(tcon_live_reg[1]))
        else $error("terminal switches moved before completion");

    chk_tcon_top_bit: assert property (
        @(posedge clk) disable iff (rst)
        $rose(rd_valid_reg) && $past(cmd_bus.tcon_hit) |-> rd_data_reg[8])
        else $error("terminal control top bit read as zero");

    chk_wiper_kept: assert property (
        @(posedge clk) disable iff (rst)
        exec && cmd_bus.tcon_hit && !hold_reset
        |=> $stable(wiper_reg[0]) && $stable(wiper_reg[1]) &&
            $stable(wiper_reg[2]) && $stable(wiper_reg[3]))
        else $error("terminal control write changed a wiper");

endmodule // qpr_regmap

/* File: verif/qpr_host_model.sv */
`timescale 1ns/1ns
module qpr_host_model
    import qpr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       cmd_accept,
    input  wire logic       rd_valid,
    input  wire logic [8:0] rd_data,
    output logic            cs_n,
    output logic            cmd_valid,
    output qpr_op_type      cmd_op,
    output logic [3:0]      cmd_addr,
    output logic [8:0]      cmd_wdata,
    output logic            cmd_complete
);
    initial begin
        cs_n         = 1'b1;
        cmd_valid    = 1'b0;
        cmd_op       = QPR_OP_READ;
        cmd_addr     = 4'h0;
        cmd_wdata    = 9'h000;
        cmd_complete = 1'b0;
    end

    // chip select passes a filter, so hold it well past it
    task automatic set_cs(input logic level);
        @(posedge clk);
        cs_n <= level;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic issue(input qpr_op_type op, input logic [3:0] addr,
                         input logic [8:0] wdata, output logic acc,
                         output logic rv, output logic [8:0] rd);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_addr  <= addr;
        cmd_wdata <= wdata;
        @(negedge clk);
        acc = cmd_accept;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // released fields carry junk, not the last value
        cmd_addr  <= ~addr;
        cmd_wdata <= ~wdata;
        @(negedge clk);
        rv = rd_valid;
        rd = rd_data;
    endtask

    task automatic finish_cmd();
        @(posedge clk);
        cmd_complete <= 1'b1;
        @(posedge clk);
        cmd_complete <= 1'b0;
        @(negedge clk);
    endtask

    // after a reset event the host puts its terminal setup back
    task automatic restore_tcon(input logic [8:0] lo, input logic [8:0] hi);
        logic       a;
        logic       v;
        logic [8:0] d;
        issue(QPR_OP_WRITE, ADDR_TERM_CTRL_LOW, lo, a, v, d);
        issue(QPR_OP_WRITE, ADDR_TERM_CTRL_HIGH, hi, a, v, d);
        finish_cmd();
    endtask
endmodule // qpr_host_model

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb;
    import qpr_pkg::*;
    logic            clk;
    logic            rst;
    logic            reset_pin_n;
    logic            cs_n;
    logic            cmd_valid;
    qpr_op_type      cmd_op;
    logic [3:0]      cmd_addr;
    logic [8:0]      cmd_wdata;
    logic            cmd_complete;
    logic            cmd_accept;
    logic            cmd_error;
    logic            rd_valid;
    logic [8:0]      rd_data;
    logic [3:0][8:0] wiper_code;
    logic [3:0]      net_shutdown;
    logic [3:0]      end_a_connect;
    logic [3:0]      wiper_connect;
    logic [3:0]      end_b_connect;
    logic            acc;
    logic            rv;
    logic [8:0]      rd;
    int              err_total = 0;
    int              checks_done = 0;
    int              cycles = 0;

    qpr_regmap u_qpr_regmap (
        .clk(clk), .rst(rst), .cs_n(cs_n), .reset_pin_n(reset_pin_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_complete(cmd_complete),
        .cmd_accept(cmd_accept), .cmd_error(cmd_error),
        .rd_valid(rd_valid), .rd_data(rd_data), .wiper_code(wiper_code),
        .net_shutdown(net_shutdown), .end_a_connect(end_a_connect),
        .wiper_connect(wiper_connect), .end_b_connect(end_b_connect));

    qpr_host_model u_qpr_host_model (
        .clk(clk), .cmd_accept(cmd_accept), .rd_valid(rd_valid),
        .rd_data(rd_data), .cs_n(cs_n), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_complete(cmd_complete));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [8:0] seen,
                       input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [3:0] waddr(input int i);
        return 4'(i < 2 ? i : i + 4);
    endfunction

    task automatic cmd(input qpr_op_type op, input logic [3:0] a,
                       input logic [8:0] d);
        u_qpr_host_model.issue(op, a, d, acc, rv, rd);
    endtask

    task automatic check_defaults();
        for (int i = 0; i < 4; i++)
            chk("wiper code", wiper_code[i], WIPER_RESET_8BIT);
        chk("shutdown", 9'(net_shutdown), 9'h000);
        chk("end a", 9'(end_a_connect), 9'h00f);
        chk("wiper conn", 9'(wiper_connect), 9'h00f);
        chk("end b", 9'(end_b_connect), 9'h00f);
    endtask

    task automatic test_reset();
        check_defaults();
        for (int i = 0; i < 4; i++) begin
            cmd(QPR_OP_READ, waddr(i), 9'h000);
            chk("wiper read", rd, WIPER_RESET_8BIT);
        end
        cmd(QPR_OP_READ, ADDR_TERM_CTRL_LOW, 9'h000);
        chk("tcon low", rd, TCON_RESET);
        cmd(QPR_OP_READ, ADDR_TERM_CTRL_HIGH, 9'h000);
        chk("tcon high", rd, TCON_RESET);
        $display("test reset values done");
    endtask

    task automatic test_legal();
        logic wp;
        logic tc;
        logic ok;
        for (int a = 0; a < 16; a++) begin
            for (int o = 0; o < 4; o++) begin
                wp = (a < 2) || (a == 6) || (a == 7);
                tc = (a == 4) || (a == 10);
                ok = wp || (tc && (o == 0 || o == 3));
                cmd(qpr_op_type'(o), 4'(a), 9'h055);
                chk("accept", 9'(acc), 9'(ok));
                chk("read valid", 9'(rv), 9'(ok && o == 3));
                chk("error", 9'(cmd_error), 9'(!ok));
                if (!ok) begin
                    cmd(QPR_OP_READ, 4'h0, 9'h000);
                    chk("ignored", 9'(acc), 9'h000);
                    u_qpr_host_model.set_cs(1'b1);
                    chk("error held", 9'(cmd_error), 9'h001);
                    u_qpr_host_model.set_cs(1'b0);
                    chk("error clear", 9'(cmd_error), 9'h000);
                end
            end
        end
        $display("test command legality done");
    endtask

    task automatic test_wiper();
        for (int i = 0; i < 4; i++) begin
            cmd(QPR_OP_WRITE, waddr(i), 9'(9'h0a0 + i));
            chk("wiper map", wiper_code[i], 9'(9'h0a0 + i));
        end
        cmd(QPR_OP_INCR, 4'h1, 9'h000);
        chk("incr", wiper_code[1], 9'h0a2);
        cmd(QPR_OP_DECR, 4'h1, 9'h000);
        cmd(QPR_OP_DECR, 4'h1, 9'h000);
        cmd(QPR_OP_READ, 4'h1, 9'h000);
        chk("decr read", rd, 9'h0a0);
        cmd(QPR_OP_WRITE, 4'h6, WIPER_FULL_8BIT);
        cmd(QPR_OP_INCR, 4'h6, 9'h000);
        chk("full scale", wiper_code[2], WIPER_FULL_8BIT);
        cmd(QPR_OP_WRITE, 4'h7, WIPER_ZERO);
        cmd(QPR_OP_DECR, 4'h7, 9'h000);
        chk("zero scale", wiper_code[3], WIPER_ZERO);
        $display("test wiper commands done");
    endtask

    task automatic test_tcon();
        cmd(QPR_OP_WRITE, ADDR_TERM_CTRL_LOW, 9'h0c1);
        cmd(QPR_OP_WRITE, ADDR_TERM_CTRL_HIGH, 9'h05a);
        cmd(QPR_OP_READ, ADDR_TERM_CTRL_LOW, 9'h000);
        chk("tcon low", rd, 9'h1c1);
        cmd(QPR_OP_READ, ADDR_TERM_CTRL_HIGH, 9'h000);
        chk("tcon high", rd, 9'h15a);
        chk("not applied", 9'(end_a_connect), 9'h00f);
        u_qpr_host_model.finish_cmd();
        chk("shutdown", 9'(net_shutdown), 9'h009);
        chk("end a", 9'(end_a_connect), 9'h00a);
        chk("wiper conn", 9'(wiper_connect), 9'h004);
        chk("end b", 9'(end_b_connect), 9'h009);
        chk("wiper kept", wiper_code[1], 9'h0a0);
        chk("wiper kept", wiper_code[2], WIPER_FULL_8BIT);
        $display("test terminal control done");
    endtask

    task automatic test_pin();
        cmd(QPR_OP_INCR, 4'h2, 9'h000);
        @(posedge clk) reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check_defaults();
        chk("error", 9'(cmd_error), 9'h000);
        cmd(QPR_OP_WRITE, 4'h0, 9'h011);
        chk("ignored", 9'(acc), 9'h000);
        chk("no error", 9'(cmd_error), 9'h000);
        @(posedge clk) reset_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        cmd(QPR_OP_READ, 4'h0, 9'h000);
        chk("wiper read", rd, WIPER_RESET_8BIT);
        $display("test reset pin done");
    endtask

    task automatic test_por();
        cmd(QPR_OP_WRITE, 4'h7, 9'h033);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check_defaults();
        u_qpr_host_model.set_cs(1'b1);
        u_qpr_host_model.set_cs(1'b0);
        u_qpr_host_model.restore_tcon(9'h0c1, 9'h05a);
        chk("restored", 9'(net_shutdown), 9'h009);
        $display("test power-on reset done");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        reset_pin_n = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        u_qpr_host_model.set_cs(1'b0);
        test_reset();
        test_legal();
        test_wiper();
        test_tcon();
        test_pin();
        test_por();
        report_and_stop();
    end
endmodule // tb
